// [side_bus_pkg.sv]
// Constants shared by the side bus endpoint and its dispatch formatter
package side_bus_pkg;
  // Dispatch kind tags on side-bus bits 79:78
  localparam logic [1:0] KIND_INT_STORE = 2'b00;
  localparam logic [1:0] KIND_READBACK  = 2'b01;
  localparam logic [1:0] KIND_NORMAL    = 2'b10;
  localparam logic [1:0] KIND_LOAD      = 2'b11;

  // Function field codes sent by the cache controller
  localparam logic [3:0] FUNC_INTERRUPT  = 4'h2;
  localparam logic [3:0] FUNC_INVALIDATE = 4'ha;

  // Side-bus field positions
  localparam int TB_W         = 80;
  localparam int TB_CC_W      = 40;
  localparam int KIND_LSB     = 78;
  localparam int SLOT_LSB     = 74;
  localparam int SPEC_A_LSB   = 65;
  localparam int SPEC_W       = 9;
  localparam int OP_W         = 28;
  localparam int DATA_W       = 64;
  localparam int LINE_LSB     = 5;
  localparam int IRQ_LSB      = 29;
  localparam int IRQ_W        = 11;
  localparam int FPR_IDX_W    = 5;
  localparam int VALID_PER_ENTRY = 4;

  // Store bus timing, in clocks
  localparam int STORE_OE_DELAY = 2;
  localparam int BYPASS_DELAY   = 2;

  // Register map (byte addresses)
  localparam int         REG_ADDR_W    = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_IRQ       = 8'h08;
  localparam logic [7:0] REG_INV_COUNT = 8'h0c;
  localparam int CTRL_DISPATCH_EN = 0;
  localparam int CTRL_INVAL_EN    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int INV_COUNT_W = 16;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic       HRESP_OKAY    = 1'b0;
endpackage : side_bus_pkg

// [dispatch_formatter.sv]
// Packs one processor-to-float-chip dispatch into the 80-bit side-bus word
`timescale 1ns/1ps
module dispatch_formatter
  import side_bus_pkg::*;
(
  input  wire logic [1:0]        kind,
  input  wire logic [3:0]        slot_valid,
  input  wire logic [SPEC_W-1:0] spec_a,
  input  wire logic [SPEC_W-1:0] spec_b,
  input  wire logic [OP_W-1:0]   op_a,
  input  wire logic [OP_W-1:0]   op_b,
  input  wire logic [DATA_W-1:0] data,
  output logic      [TB_W-1:0]   word
);
  always_comb
  begin
    if (kind == KIND_NORMAL || kind == KIND_READBACK)
    begin
      word = {kind, slot_valid, spec_a, spec_b, op_a, op_b};
    end
    else
    begin
      // Unused bits 76:74 and 64 go out low
      word = {kind, 1'b1, 3'b000, spec_a, 1'b0, data};
    end
  end
endmodule : dispatch_formatter

// [side_bus_endpoint.sv]
// Processor and float chip side-bus endpoint with AHB-Lite control registers
//
// Notes on behaviour
// - Invalidate is one-way; nothing is returned and no completion acknowledge exists.
// - Each invalidate clears one 32-byte data cache line, both 16-byte ports.
// - Valid store holds four word valid bits per entry; invalidate clears two entries.
// - Float chip releases store bus two clocks after enable drops, drives two after return.
// - Buffers drive write data in clock 5, enable returns then, chip drives in 7.
// - Clocks 1 and 3 of a cache write are controller-owned.
// - Each buffer-owned cycle writes 16 bytes, one write enable per 4 bytes.
// - Bypass low routes load data onto the store bus, taking two clocks.
// - Clocks 1 to 4 of a cache read are controller-owned; 16 bytes each.
// - Interrupt status is sent only in controller-owned state, on each register change.
// - Interrupt status sits on bits 39:29: three enables, pending field, NMI, bus error.
// - Bits 79:72 join only processor and float chip.
// - Dispatch tag on bits 79:78: 10 normal, 01 readback, 00 store, 11 load.
// - Normal dispatch: two 9-bit memory ops and two 28-bit arithmetic ops.
// - Four slot valid bits on 77:74; only valid slots execute.
// - Readback replaces memory op A; only time the float chip drives the side bus.
// - Integer store carries 64-bit data forwarded onto the store data pins.
// - Register load puts float register on 73:65 and data on 63:0.
// - Function code ten invalidates one 32-byte data cache line.
`timescale 1ns/1ps
module side_bus_endpoint
  import side_bus_pkg::*;
#(
  parameter int DC_ENTRIES = 512,
  parameter int STORE_W    = 128,
  parameter int FPR_COUNT  = 32
)
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  // Side bus pins
  input  wire logic [TB_CC_W-1:0]     tbus_in,
  input  wire logic [3:0]             function_field,
  input  wire logic                   cc_owns_bus,
  output logic      [TB_W-1:0]        tbus_out,
  output logic                        tbus_hi_oe,
  output logic                        tbus_lo_oe,
  // Store data bus pins
  input  wire logic                   store_bus_output_enable_n,
  input  wire logic                   bypass_n,
  input  wire logic [STORE_W-1:0]     load_data_in,
  output logic      [STORE_W-1:0]     store_data_out,
  output logic                        store_data_oe,
  // Dispatch request from the issue logic
  input  wire logic                   dispatch_valid,
  output logic                        dispatch_ready,
  input  wire logic [1:0]             dispatch_kind,
  input  wire logic [3:0]             dispatch_slot_valid,
  input  wire logic [SPEC_W-1:0]      dispatch_spec_a,
  input  wire logic [SPEC_W-1:0]      dispatch_spec_b,
  input  wire logic [OP_W-1:0]        dispatch_op_a,
  input  wire logic [OP_W-1:0]        dispatch_op_b,
  input  wire logic [DATA_W-1:0]      dispatch_data,
  // Float chip results and controller interrupt status
  output logic      [3:0]             slot_exec,
  output logic                        readback_valid,
  output logic      [DATA_W-1:0]      readback_data,
  output logic      [IRQ_W-1:0]       irq_status,
  // Data cache valid store access
  input  wire logic                   fill_valid,
  input  wire logic [$clog2(DC_ENTRIES)-1:0] fill_index,
  input  wire logic [VALID_PER_ENTRY-1:0]    fill_mask,
  input  wire logic [$clog2(DC_ENTRIES)-1:0] lookup_index,
  output logic      [VALID_PER_ENTRY-1:0]    lookup_valid
);
  localparam int IDX_W = $clog2(DC_ENTRIES);

  function automatic logic [IDX_W-1:0] entry_of(input logic [IDX_W-2:0] line, input logic half);
    entry_of = {line, half};
  endfunction : entry_of

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [TB_CC_W-1:0] tb_s1_ff, tb_s2_ff;
  logic [3:0]         fn_s1_ff, fn_s2_ff;
  logic               own_s1_ff, own_s2_ff;
  logic               foe_s1_ff, foe_s2_ff;
  logic               byp_s1_ff, byp_s2_ff;
  logic [STORE_W-1:0] ld_s1_ff, ld_s2_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tb_s1_ff  <= '0;
      tb_s2_ff  <= '0;
      fn_s1_ff  <= '0;
      fn_s2_ff  <= '0;
      own_s1_ff <= 1'b0;
      own_s2_ff <= 1'b0;
      foe_s1_ff <= 1'b0;
      foe_s2_ff <= 1'b0;
      byp_s1_ff <= 1'b1;
      byp_s2_ff <= 1'b1;
      ld_s1_ff  <= '0;
      ld_s2_ff  <= '0;
    end
    else
    begin
      tb_s1_ff  <= tbus_in;
      tb_s2_ff  <= tb_s1_ff;
      fn_s1_ff  <= function_field;
      fn_s2_ff  <= fn_s1_ff;
      own_s1_ff <= cc_owns_bus;
      own_s2_ff <= own_s1_ff;
      foe_s1_ff <= store_bus_output_enable_n;
      foe_s2_ff <= foe_s1_ff;
      byp_s1_ff <= bypass_n;
      byp_s2_ff <= byp_s1_ff;
      ld_s1_ff  <= load_data_in;
      ld_s2_ff  <= ld_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states
  logic [1:0]             ctrl_ff;
  logic [INV_COUNT_W-1:0] inv_count_ff;
  logic                   wr_pend_ff;
  logic [REG_ADDR_W-1:0]  wr_addr_ff;
  logic [31:0]            hrdata_ff;
  logic                   bus_take;
  logic                   inv_fire;
  logic [STORE_OE_DELAY-1:0] drv_sr_ff;
  logic [BYPASS_DELAY-1:0]   byp_sr_ff;

  assign bus_take  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_ff;

  function automatic logic [31:0] reg_read(input logic [REG_ADDR_W-1:0] a);
    reg_read = '0;
    unique case (a)
      REG_CTRL:      reg_read[1:0] = ctrl_ff;
      REG_STATUS:    reg_read[2:0] = {byp_sr_ff[BYPASS_DELAY-1], drv_sr_ff[STORE_OE_DELAY-1], own_s2_ff};
      REG_IRQ:       reg_read[IRQ_W-1:0] = irq_status;
      REG_INV_COUNT: reg_read[INV_COUNT_W-1:0] = inv_count_ff;
      default:       reg_read = '0;
    endcase
  endfunction : reg_read

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata_ff  <= '0;
    end
    else
    begin
      wr_pend_ff <= bus_take && hwrite;
      if (bus_take)
      begin
        wr_addr_ff <= haddr[REG_ADDR_W-1:0];
      end
      if (bus_take && !hwrite)
      begin
        hrdata_ff <= reg_read(haddr[REG_ADDR_W-1:0]);
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff <= CTRL_RESET;
    end
    else if (wr_pend_ff && wr_addr_ff == REG_CTRL)
    begin
      ctrl_ff <= hwdata[1:0];
    end
  end

  // A write clears the count; an invalidate in the same cycle still counts
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      inv_count_ff <= '0;
    end
    else if (wr_pend_ff && wr_addr_ff == REG_INV_COUNT)
    begin
      inv_count_ff <= inv_fire ? INV_COUNT_W'(1) : '0;
    end
    else if (inv_fire)
    begin
      inv_count_ff <= inv_count_ff + INV_COUNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller-owned cycles: invalidate and interrupt status
  logic [VALID_PER_ENTRY-1:0] dc_valid_ff [DC_ENTRIES];
  logic [IDX_W-2:0]           inv_line;
  logic [IRQ_W-1:0]           irq_ff;

  // No answer is ever returned for an invalidate
  assign inv_fire = own_s2_ff && fn_s2_ff == FUNC_INVALIDATE && ctrl_ff[CTRL_INVAL_EN];
  // Synonym bits 3:0 and unused bit 4 play no part in the clear
  assign inv_line = tb_s2_ff[LINE_LSB +: IDX_W-1];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < DC_ENTRIES; i++)
      begin
        dc_valid_ff[i] <= '0;
      end
    end
    else
    begin
      if (fill_valid)
      begin
        dc_valid_ff[fill_index] <= dc_valid_ff[fill_index] | fill_mask;
      end
      // Invalidate wins over a fill of the same line
      if (inv_fire)
      begin
        dc_valid_ff[entry_of(inv_line, 1'b0)] <= '0;
        dc_valid_ff[entry_of(inv_line, 1'b1)] <= '0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lookup_valid <= '0;
    end
    else
    begin
      lookup_valid <= dc_valid_ff[lookup_index];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_ff <= '0;
    end
    else if (own_s2_ff && fn_s2_ff == FUNC_INTERRUPT)
    begin
      irq_ff <= tb_s2_ff[IRQ_LSB +: IRQ_W];
    end
  end
  assign irq_status = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Store data bus: driver release, bypass routing, integer store forwarding
  logic [STORE_W-1:0] ld_p_ff [BYPASS_DELAY];
  logic [DATA_W-1:0]  int_data_ff;
  logic [STORE_W-1:0] store_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      drv_sr_ff <= '1;
      byp_sr_ff <= '0;
    end
    else
    begin
      drv_sr_ff <= {drv_sr_ff[STORE_OE_DELAY-2:0], !foe_s2_ff};
      byp_sr_ff <= {byp_sr_ff[BYPASS_DELAY-2:0], !byp_s2_ff};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < BYPASS_DELAY; i++)
      begin
        ld_p_ff[i] <= '0;
      end
    end
    else
    begin
      ld_p_ff[0] <= ld_s2_ff;
      for (int i = 1; i < BYPASS_DELAY; i++)
      begin
        ld_p_ff[i] <= ld_p_ff[i-1];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      store_ff <= '0;
    end
    else if (byp_sr_ff[BYPASS_DELAY-1])
    begin
      store_ff <= ld_p_ff[BYPASS_DELAY-1];
    end
    else
    begin
      store_ff <= STORE_W'(int_data_ff);
    end
  end

  // Enable tracks the delayed pin, so buffers never fight the chip
  assign store_data_oe  = drv_sr_ff[STORE_OE_DELAY-1];
  assign store_data_out = store_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch to the float chip and register readback
  logic [TB_W-1:0]          word;
  logic [TB_W-1:0]          tb_out_ff;
  logic                     hi_oe_ff, lo_oe_ff;
  logic                     disp_fire;
  logic                     rb_due;
  logic [DATA_W-1:0]        fpr_ff [FPR_COUNT];
  logic [FPR_IDX_W-1:0]     fpr_idx;

  dispatch_formatter u_fmt
  (
    .kind       (dispatch_kind),
    .slot_valid (dispatch_slot_valid),
    .spec_a     (dispatch_spec_a),
    .spec_b     (dispatch_spec_b),
    .op_a       (dispatch_op_a),
    .op_b       (dispatch_op_b),
    .data       (dispatch_data),
    .word       (word)
  );

  // A readback needs the low bits in the following cycle, so hold off one dispatch
  assign rb_due = hi_oe_ff && tb_out_ff[KIND_LSB +: 2] == KIND_READBACK && tb_out_ff[SLOT_LSB+3];
  assign dispatch_ready = ctrl_ff[CTRL_DISPATCH_EN] && !own_s2_ff && !rb_due;
  assign disp_fire      = dispatch_valid && dispatch_ready;
  assign fpr_idx        = tb_out_ff[SPEC_A_LSB +: FPR_IDX_W];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tb_out_ff <= '0;
      hi_oe_ff  <= 1'b0;
      lo_oe_ff  <= 1'b0;
    end
    else if (rb_due)
    begin
      tb_out_ff <= TB_W'(fpr_ff[fpr_idx]);
      hi_oe_ff  <= 1'b0;
      lo_oe_ff  <= 1'b1;
    end
    else
    begin
      tb_out_ff <= disp_fire ? word : '0;
      hi_oe_ff  <= disp_fire;
      lo_oe_ff  <= disp_fire;
    end
  end

  assign tbus_out   = tb_out_ff;
  assign tbus_hi_oe = hi_oe_ff;
  assign tbus_lo_oe = lo_oe_ff;

  // Float chip side: act on the word it sees on the bus
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slot_exec      <= '0;
      readback_valid <= 1'b0;
      readback_data  <= '0;
      int_data_ff    <= '0;
      for (int i = 0; i < FPR_COUNT; i++)
      begin
        fpr_ff[i] <= '0;
      end
    end
    else
    begin
      slot_exec      <= '0;
      readback_valid <= rb_due;
      if (rb_due)
      begin
        readback_data <= fpr_ff[fpr_idx];
      end
      if (hi_oe_ff)
      begin
        unique case (tb_out_ff[KIND_LSB +: 2])
          KIND_NORMAL:    slot_exec <= tb_out_ff[SLOT_LSB +: 4];
          KIND_READBACK:  slot_exec <= {1'b0, tb_out_ff[SLOT_LSB +: 3]};
          KIND_INT_STORE: int_data_ff <= tb_out_ff[DATA_W-1:0];
          KIND_LOAD:      fpr_ff[fpr_idx] <= tb_out_ff[DATA_W-1:0];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_store_release: assert property (@(posedge clk) disable iff (reset)
    $rose(foe_s2_ff) && !$past(foe_s2_ff, 2) |-> ##1 store_data_oe ##1 !store_data_oe)
    else $error("store bus not released two clocks after enable drop");

  chk_store_resume: assert property (@(posedge clk) disable iff (reset)
    $fell(foe_s2_ff) |-> ##2 store_data_oe)
    else $error("store bus not driven two clocks after enable return");

  chk_inval_two_entries: assert property (@(posedge clk) disable iff (reset)
    inv_fire |=> dc_valid_ff[entry_of($past(inv_line), 1'b0)] == '0
             && dc_valid_ff[entry_of($past(inv_line), 1'b1)] == '0)
    else $error("invalidate left a valid entry in the line");

  chk_dispatch_tag: assert property (@(posedge clk) disable iff (reset)
    hi_oe_ff |-> tb_out_ff[KIND_LSB +: 2] == $past(dispatch_kind) && $past(disp_fire))
    else $error("dispatch tag does not match requested kind");

  chk_slot_gate: assert property (@(posedge clk) disable iff (reset)
    slot_exec != 4'h0 |-> (slot_exec & ~$past(tb_out_ff[SLOT_LSB +: 4])) == 4'h0 && $past(hi_oe_ff))
    else $error("slot executed without its valid bit");

  chk_readback_only: assert property (@(posedge clk) disable iff (reset)
    lo_oe_ff && !hi_oe_ff |-> $past(hi_oe_ff) && $past(tb_out_ff[KIND_LSB +: 2]) == KIND_READBACK
                             && readback_valid)
    else $error("float chip drove side bus outside a readback");

  chk_irq_capture: assert property (@(posedge clk) disable iff (reset)
    own_s2_ff && fn_s2_ff == FUNC_INTERRUPT |=> irq_status == $past(tb_s2_ff[IRQ_LSB +: IRQ_W]))
    else $error("interrupt status not captured from bits 39:29");

  chk_bypass_route: assert property (@(posedge clk) disable iff (reset)
    $fell(byp_s2_ff) ##1 !byp_s2_ff |-> ##1 byp_sr_ff[BYPASS_DELAY-1] ##1 store_ff == $past(ld_p_ff[BYPASS_DELAY-1]))
    else $error("bypass did not route load data after two clocks");

  chk_inval_no_answer: assert property (@(posedge clk) disable iff (reset)
    inv_fire |=> !lo_oe_ff || $past(disp_fire))
    else $error("side bus driven in answer to an invalidate");
endmodule : side_bus_endpoint

// [cc_model.sv]
// Cache controller model: side-bus ownership, function codes, store enable, bypass and load data
`timescale 1ns/1ps
module cc_model
  import side_bus_pkg::*;
(
  input  wire logic         clk,
  output logic              cc_owns_bus,
  output logic [3:0]        function_field,
  output logic [TB_CC_W-1:0] tbus_in,
  output logic              store_bus_output_enable_n,
  output logic              bypass_n,
  output logic [127:0]      load_data_in
);
  initial
  begin
    cc_owns_bus = 1'b0;
    function_field = 4'h0;
    tbus_in = '0;
    store_bus_output_enable_n = 1'b0;
    bypass_n = 1'b1;
    load_data_in = 128'h0123456789abcdef_f0e1d2c3b4a59687;
  end

  // Load bus only holds still while a bypass read is in progress
  always @(posedge clk)
    if (bypass_n)
      load_data_in <= ~load_data_in;

  ////////////////////////////////////////////////////////////////////////////
  // One controller-owned operation; nothing is awaited back from the device
  task op(input logic [3:0] func, input logic [TB_CC_W-1:0] bits);
    @(posedge clk);
    cc_owns_bus <= 1'b1;
    repeat (3) @(posedge clk);
    function_field <= func;
    tbus_in <= bits;
    @(posedge clk);
    function_field <= 4'h0;
    repeat (4) @(posedge clk);
    cc_owns_bus <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one
    tbus_in <= ~bits;
    repeat (3) @(posedge clk);
  endtask : op

  task pins(input logic oe_n, input logic byp_n);
    store_bus_output_enable_n <= oe_n;
    bypass_n <= byp_n;
  endtask : pins
endmodule : cc_model

// [side_bus_endpoint_bench.sv]
// Self-checking bench for the side bus endpoint
`timescale 1ns/1ps
module side_bus_endpoint_bench
  import side_bus_pkg::*;
;
  logic               clk, reset, hsel, hwrite, hreadyout, hresp, ok;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans, dispatch_kind;
  logic [2:0]         hsize;
  logic [TB_CC_W-1:0] tbus_in;
  logic [3:0]         function_field, dispatch_slot_valid, slot_exec, fill_mask, lookup_valid, se2;
  logic               cc_owns_bus, tbus_hi_oe, tbus_lo_oe, store_en_n, bypass_n, store_data_oe;
  logic [TB_W-1:0]    tbus_out, w1, w2;
  logic [127:0]       load_data_in, store_data_out;
  logic               dispatch_valid, dispatch_ready, readback_valid, fill_valid, hi1, hi2, lo2, rv2, r1;
  logic [8:0]         dispatch_spec_a, dispatch_spec_b, fill_index, lookup_index;
  logic [27:0]        dispatch_op_a, dispatch_op_b;
  logic [63:0]        dispatch_data, readback_data, rd2;
  logic [10:0]        irq_status;
  int                 n_errors, comparisons, cycles, i, en;

  side_bus_endpoint u_side_bus_endpoint (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tbus_in(tbus_in),
    .function_field(function_field), .cc_owns_bus(cc_owns_bus), .tbus_out(tbus_out),
    .tbus_hi_oe(tbus_hi_oe), .tbus_lo_oe(tbus_lo_oe), .store_bus_output_enable_n(store_en_n),
    .bypass_n(bypass_n), .load_data_in(load_data_in), .store_data_out(store_data_out),
    .store_data_oe(store_data_oe), .dispatch_valid(dispatch_valid), .dispatch_ready(dispatch_ready),
    .dispatch_kind(dispatch_kind), .dispatch_slot_valid(dispatch_slot_valid),
    .dispatch_spec_a(dispatch_spec_a), .dispatch_spec_b(dispatch_spec_b), .dispatch_op_a(dispatch_op_a),
    .dispatch_op_b(dispatch_op_b), .dispatch_data(dispatch_data), .slot_exec(slot_exec),
    .readback_valid(readback_valid), .readback_data(readback_data), .irq_status(irq_status),
    .fill_valid(fill_valid), .fill_index(fill_index), .fill_mask(fill_mask),
    .lookup_index(lookup_index), .lookup_valid(lookup_valid));

  cc_model u_cc_model (.clk(clk), .cc_owns_bus(cc_owns_bus), .function_field(function_field),
    .tbus_in(tbus_in), .store_bus_output_enable_n(store_en_n), .bypass_n(bypass_n),
    .load_data_in(load_data_in));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Ready is combinational, so it is judged at the falling edge before the taking edge
  task dispatch(input logic [1:0] k, input logic [3:0] sv, input logic [8:0] sa, input logic [63:0] d);
    dispatch_valid <= 1'b1;
    dispatch_kind <= k;
    dispatch_slot_valid <= sv;
    dispatch_spec_a <= sa;
    dispatch_data <= d;
    do begin @(negedge clk); ok = dispatch_ready; @(posedge clk); end while (ok !== 1'b1);
    dispatch_valid <= 1'b0;
    #1 w1 = tbus_out;
    {hi1, r1} = {tbus_hi_oe, dispatch_ready};
    @(posedge clk);
    #1 {se2, rv2, rd2, w2, hi2, lo2} = {slot_exec, readback_valid, readback_data, tbus_out, tbus_hi_oe, tbus_lo_oe};
    @(posedge clk);
  endtask : dispatch

  task conclude;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs well under two thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude;
    end
  end

  initial
  begin
    {reset, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 68'h0, 3'h2};
    {dispatch_valid, dispatch_kind, dispatch_slot_valid, dispatch_spec_a, dispatch_data} = '0;
    {dispatch_spec_b, dispatch_op_a, dispatch_op_b} = {9'h0c3, 28'h1234567, 28'h89abcde};
    {fill_valid, fill_index, fill_mask, lookup_index} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h3);
    check(hresp, HRESP_OKAY);
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    $display("registers test done");
    dispatch(KIND_NORMAL, 4'hb, 9'h1a5, 64'h0);
    check(w1, {KIND_NORMAL, 4'hb, 9'h1a5, 9'h0c3, 28'h1234567, 28'h89abcde});
    check(hi1, 1'b1);
    check(r1, 1'b1);
    check(se2, 4'hb);
    dispatch(KIND_LOAD, 4'h8, 9'h005, 64'hfeedface01234567);
    check(w1, {KIND_LOAD, 4'h8, 9'h005, 1'b0, 64'hfeedface01234567});
    dispatch(KIND_READBACK, 4'h8, 9'h005, 64'h0);
    check(w1[79:74], {KIND_READBACK, 4'h8});
    check({rv2, lo2, hi2}, 3'b110);
    check(r1, 1'b0);
    check({rd2, w2[63:0]}, {2{64'hfeedface01234567}});
    dispatch(KIND_INT_STORE, 4'h8, 9'h011, 64'h0123456789abcdef);
    check(w1, {KIND_INT_STORE, 4'h8, 9'h011, 1'b0, 64'h0123456789abcdef});
    repeat (2) @(posedge clk);
    check(store_data_out[63:0], 64'h0123456789abcdef);
    $display("dispatch test done");
    for (i = 0; i < 3; i++)
    begin
      {fill_valid, fill_index, fill_mask} <= {1'b1, 9'h06e + i[8:0], 4'hf};
      @(posedge clk);
    end
    fill_valid <= 1'b0;
    for (en = 0; en < 2; en++)
    begin
      ahb(1'b1, REG_CTRL, {30'h0, en[0], 1'b1});
      u_cc_model.op(FUNC_INVALIDATE, {27'h0, 8'h37, 1'b0, 4'h9});
      for (i = 0; i < 3; i++)
      begin
        @(posedge clk);
        lookup_index <= 9'h06e + i[8:0];
        @(posedge clk);
        #1 check(lookup_valid, (en == 1 && i < 2) ? 4'h0 : 4'hf);
      end
    end
    ahb(1'b0, REG_INV_COUNT, 32'h0);
    check(rd, 32'h1);
    $display("invalidate test done");
    u_cc_model.op(FUNC_INTERRUPT, {11'h5a3, 29'h0});
    check(irq_status, 11'h5a3);
    ahb(1'b0, REG_IRQ, 32'h0);
    check(rd, 32'h5a3);
    $display("interrupt test done");
    for (en = 1; en >= 0; en--)
    begin
      @(posedge clk);
      u_cc_model.pins(en[0], 1'b1);
      repeat (3) @(posedge clk);
      #1 check(store_data_oe, en[0]);
      @(posedge clk);
      #1 check(store_data_oe, !en[0]);
    end
    u_cc_model.pins(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    #1 check({store_data_oe, store_data_out}, {1'b1, load_data_in});
    ahb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h6);
    u_cc_model.pins(1'b0, 1'b1);
    $display("store bus test done");
    conclude;
  end
endmodule : side_bus_endpoint_bench
